// >>> core/cioc_regs.vh
`ifndef CIOC_REGS_VH
`define CIOC_REGS_VH

// ============================================================
// Timebase
`define CIOC_CLK_KHZ        25000
`define CIOC_TICK_US        1

// ============================================================
// Setting ranges in microseconds
`define CIOC_FILTER_MAX_US  24'h0F4240
`define CIOC_WIDTH_MAX_US   24'h000064
`define CIOC_DELAY_MAX_US   24'h989680

// ============================================================
// Setting widths and counts of lines
`define CIOC_FILTER_W       20
`define CIOC_WIDTH_W        7
`define CIOC_DELAY_W        24
`define CIOC_CFG_W          24
`define CIOC_IN_LINES       2
`define CIOC_OUT_LINES      4
`define CIOC_TRIG_KINDS     2

// ============================================================
// Parameter codes for the configuration port
`define CIOC_PARAM_FILTER   2'h0
`define CIOC_PARAM_WIDTH    2'h1
`define CIOC_PARAM_DELAY    2'h2

// ============================================================
// Trigger kinds and status choices
`define CIOC_TRIG_ACQ       1'h0
`define CIOC_TRIG_FRAME     1'h1
`define CIOC_STAT_FRAME_WAIT 2'h0

// ============================================================
// Reset values of the settings
`define CIOC_RST_FILTER     20'h00000
`define CIOC_RST_WIDTH      7'h00
`define CIOC_RST_DELAY      24'h000000

`endif

// >>> core/cioc_us_timer.v
`timescale 1ns/100ps

// ============================================================
// Microsecond timer: runs for i_len_us ticks, then pulses o_done.
// The prescaler starts at one so that a registered consumer sees
// exactly i_len_us * (PRE_LAST + 1) cycles from the start edge.
module cioc_us_timer #(
    parameter             LEN_W    = 24,
    parameter             PRE_W    = 5,
    parameter [PRE_W-1:0] PRE_LAST = 5'h18
) (
    // Clock and reset
    input  wire             i_sys_clk,
    input  wire             i_reset_n,
    // Control
    input  wire             i_start,
    input  wire             i_abort,
    input  wire [LEN_W-1:0] i_len_us,
    // Status
    output wire             o_busy,
    output wire             o_done
);

    localparam [LEN_W-1:0] LEN_ONE = {{(LEN_W-1){1'b0}}, 1'b1};
    localparam [PRE_W-1:0] PRE_ONE = {{(PRE_W-1){1'b0}}, 1'b1};

    reg             busy_q;
    reg             busy_d;
    reg             done_q;
    reg             done_d;
    reg [LEN_W-1:0] rem_q;
    reg [LEN_W-1:0] rem_d;
    reg [PRE_W-1:0] pre_q;
    reg [PRE_W-1:0] pre_d;

    always @* begin
        busy_d = busy_q;
        done_d = 1'b0;
        rem_d  = rem_q;
        pre_d  = pre_q;
        if (i_abort) begin
            busy_d = 1'b0;
        end else if (i_start) begin
            if (i_len_us == {LEN_W{1'b0}}) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                busy_d = 1'b1;
                rem_d  = i_len_us;
                pre_d  = PRE_ONE;
            end
        end else if (busy_q) begin
            if (pre_q == PRE_LAST) begin
                pre_d = {PRE_W{1'b0}};
                if (rem_q == LEN_ONE) begin
                    busy_d = 1'b0;
                    done_d = 1'b1;
                end else begin
                    rem_d = rem_q - LEN_ONE;
                end
            end else begin
                pre_d = pre_q + PRE_ONE;
            end
        end
    end

    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            rem_q  <= {LEN_W{1'b0}};
            pre_q  <= {PRE_W{1'b0}};
        end else begin
            busy_q <= busy_d;
            done_q <= done_d;
            rem_q  <= rem_d;
            pre_q  <= pre_d;
        end
    end

    assign o_busy = busy_q;
    assign o_done = done_q;

endmodule // cioc_us_timer

// >>> core/cioc_top.v
`timescale 1ns/100ps
`include "cioc_regs.vh"

// How it works
// - An input level counts as valid only after holding for the filter time.
// - Input pulses shorter than the filter time never reach the outputs.
// - A valid input edge appears internally three clock cycles after a nonzero filter time, four cycles after the pin edge with zero filter time.
// - Filter time is set in microseconds, zero up to one second.
// - Each of two input lines has its own filter time, picked by line select.
// - Output pulses shorter than minimum width are stretched to exactly it.
// - Output pulses at or above the minimum width pass unchanged.
// - Minimum output width is set in microseconds, zero to one hundred.
// - Each of four output lines has its own minimum width, by line select.
// - A hardware trigger takes effect a programmed delay after its arrival.
// - Trigger delay spans zero to ten million microseconds; zero means none.
// - Standard mode gives acquisition and frame start triggers own delays.
// - Legacy mode applies the delay to the acquisition start trigger only.
// - Delay is skipped when trigger mode is off or trigger is software.
// - Standard mode ready flag shows whether a frame start is accepted.
// - Legacy mode ready flag shows whether an acquisition start is accepted.
// - Ready flag is read with the frame trigger wait status choice.
// - No status reports completion of an acquisition start command.
module cioc_top #(
    parameter [23:0] FILTER_MAX_US = `CIOC_FILTER_MAX_US,
    parameter [23:0] WIDTH_MAX_US  = `CIOC_WIDTH_MAX_US,
    parameter [23:0] DELAY_MAX_US  = `CIOC_DELAY_MAX_US
) (
    // Clock and reset
    input  wire                  i_sys_clk,
    input  wire                  i_reset_n,
    // Configuration port
    input  wire                  i_cfg_we,
    input  wire [1:0]            i_cfg_param,
    input  wire [1:0]            i_io_line_select,
    input  wire                  i_trigger_kind_select,
    input  wire [23:0]           i_cfg_data,
    output wire [23:0]           o_cfg_rdata,
    // Input lines from pins
    input  wire [1:0]            i_line_in_pin,
    output wire [1:0]            o_line_in,
    // Output lines from internal logic to pins
    input  wire [3:0]            i_line_out_src,
    output wire [3:0]            o_line_out_pin,
    // Triggers, bit 0 acquisition start, bit 1 frame start
    input  wire                  i_legacy_mode,
    input  wire [1:0]            i_trig_mode_on,
    input  wire [1:0]            i_hw_trig,
    input  wire [1:0]            i_sw_trig,
    input  wire [1:0]            i_int_trig,
    output wire [1:0]            o_trig,
    output wire [1:0]            o_trig_dropped,
    // Ready status
    input  wire [1:0]            i_ready_status_select,
    input  wire                  i_acq_trig_ready,
    input  wire                  i_frame_trig_ready,
    output wire                  o_ready_flag
);

    // ============================================================
    // Shared microsecond timebase
    localparam [31:0] CYC_PER_TICK = `CIOC_CLK_KHZ * `CIOC_TICK_US / 1000;
    localparam [31:0] PRE_LAST_32  = CYC_PER_TICK - 32'h1;
    localparam        PRE_W        = 5;
    localparam [PRE_W-1:0] PRE_LAST = PRE_LAST_32[PRE_W-1:0];

    function [23:0] clamp;
        input [23:0] val;
        input [23:0] lim;
        begin
            clamp = (val > lim) ? lim : val;
        end
    endfunction

    wire [23:0] filt_val  = clamp(i_cfg_data, FILTER_MAX_US);
    wire [23:0] width_val = clamp(i_cfg_data, WIDTH_MAX_US);
    wire [23:0] delay_val = clamp(i_cfg_data, DELAY_MAX_US);

    wire [`CIOC_FILTER_W*2-1:0] filt_all;
    wire [`CIOC_WIDTH_W*4-1:0]  width_all;
    wire [`CIOC_DELAY_W*2-1:0]  delay_all;
    wire [1:0]                  trig_busy;

    // ============================================================
    // Input filters
    genvar gi;
    generate
        for (gi = 0; gi < `CIOC_IN_LINES; gi = gi + 1) begin : g_in
            reg  [`CIOC_FILTER_W-1:0] filt_us_q;
            reg                       meta_q;
            reg                       sync_q;
            reg                       cand_q;
            reg                       stable_q;
            wire                      change;
            wire                      done;

            always @(posedge i_sys_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    filt_us_q <= `CIOC_RST_FILTER;
                end else if (i_cfg_we && i_cfg_param == `CIOC_PARAM_FILTER &&
                             i_io_line_select == gi) begin
                    filt_us_q <= filt_val[`CIOC_FILTER_W-1:0];
                end
            end

            always @(posedge i_sys_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    meta_q   <= 1'b0;
                    sync_q   <= 1'b0;
                    cand_q   <= 1'b0;
                    stable_q <= 1'b0;
                end else begin
                    meta_q <= i_line_in_pin[gi];
                    sync_q <= meta_q;
                    cand_q <= sync_q;
                    if (done) begin
                        stable_q <= cand_q;
                    end
                end
            end

            assign change = sync_q ^ cand_q;

            cioc_us_timer #(
                .LEN_W    (`CIOC_FILTER_W),
                .PRE_W    (PRE_W),
                .PRE_LAST (PRE_LAST)
            ) u_filt (
                .i_sys_clk (i_sys_clk),
                .i_reset_n (i_reset_n),
                .i_start   (change),
                .i_abort   (1'b0),
                .i_len_us  (filt_us_q),
                .o_busy    (),
                .o_done    (done)
            );

            assign o_line_in[gi] = stable_q;
            assign filt_all[gi*`CIOC_FILTER_W +: `CIOC_FILTER_W] = filt_us_q;
        end
    endgenerate

    // ============================================================
    // Output pulse stretchers
    generate
        for (gi = 0; gi < `CIOC_OUT_LINES; gi = gi + 1) begin : g_out
            reg  [`CIOC_WIDTH_W-1:0] width_us_q;
            reg                      src_prev_q;
            reg                      pin_q;
            wire                     rise;
            wire                     busy;

            always @(posedge i_sys_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    width_us_q <= `CIOC_RST_WIDTH;
                end else if (i_cfg_we && i_cfg_param == `CIOC_PARAM_WIDTH &&
                             i_io_line_select == gi) begin
                    width_us_q <= width_val[`CIOC_WIDTH_W-1:0];
                end
            end

            assign rise = i_line_out_src[gi] & ~src_prev_q;

            always @(posedge i_sys_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    src_prev_q <= 1'b0;
                    pin_q      <= 1'b0;
                end else begin
                    src_prev_q <= i_line_out_src[gi];
                    pin_q      <= i_line_out_src[gi] | busy;
                end
            end

            cioc_us_timer #(
                .LEN_W    (`CIOC_WIDTH_W),
                .PRE_W    (PRE_W),
                .PRE_LAST (PRE_LAST)
            ) u_width (
                .i_sys_clk (i_sys_clk),
                .i_reset_n (i_reset_n),
                .i_start   (rise),
                .i_abort   (1'b0),
                .i_len_us  (width_us_q),
                .o_busy    (busy),
                .o_done    ()
            );

            assign o_line_out_pin[gi] = pin_q;
            assign width_all[gi*`CIOC_WIDTH_W +: `CIOC_WIDTH_W] = width_us_q;
        end
    endgenerate

    // ============================================================
    // Trigger delays
    generate
        for (gi = 0; gi < `CIOC_TRIG_KINDS; gi = gi + 1) begin : g_trig
            reg  [`CIOC_DELAY_W-1:0] delay_us_q;
            reg                      trig_q;
            reg                      drop_q;
            wire                     applies;
            wire                     zero;
            wire                     start;
            wire                     direct;
            wire                     busy;
            wire                     done;

            always @(posedge i_sys_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    delay_us_q <= `CIOC_RST_DELAY;
                end else if (i_cfg_we && i_cfg_param == `CIOC_PARAM_DELAY &&
                             i_trigger_kind_select == gi) begin
                    delay_us_q <= delay_val[`CIOC_DELAY_W-1:0];
                end
            end

            assign applies = i_trig_mode_on[gi] &
                             ((gi == `CIOC_TRIG_ACQ) | ~i_legacy_mode);
            assign zero    = (delay_us_q == {`CIOC_DELAY_W{1'b0}});
            assign start   = i_hw_trig[gi] & applies & ~zero & ~busy;
            assign direct  = i_trig_mode_on[gi] ?
                             (i_sw_trig[gi] |
                              (i_hw_trig[gi] & (~applies | zero))) :
                             i_int_trig[gi];

            always @(posedge i_sys_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    trig_q <= 1'b0;
                    drop_q <= 1'b0;
                end else begin
                    trig_q <= direct | done;
                    drop_q <= i_hw_trig[gi] & applies & ~zero & busy;
                end
            end

            cioc_us_timer #(
                .LEN_W    (`CIOC_DELAY_W),
                .PRE_W    (PRE_W),
                .PRE_LAST (PRE_LAST)
            ) u_delay (
                .i_sys_clk (i_sys_clk),
                .i_reset_n (i_reset_n),
                .i_start   (start),
                .i_abort   (~applies),
                .i_len_us  (delay_us_q),
                .o_busy    (busy),
                .o_done    (done)
            );

            assign o_trig[gi]         = trig_q;
            assign o_trig_dropped[gi] = drop_q;
            assign trig_busy[gi]      = busy;
            assign delay_all[gi*`CIOC_DELAY_W +: `CIOC_DELAY_W] = delay_us_q;
        end
    endgenerate

    // ============================================================
    // Ready flag
    // A pending delayed frame start (acquisition start in legacy mode) makes the flag false, since a second
    // hardware trigger of that kind would be dropped until it fires.
    reg ready_q;
    reg ready_d;

    always @* begin
        ready_d = 1'b0;
        if (i_ready_status_select == `CIOC_STAT_FRAME_WAIT) begin
            if (i_legacy_mode) begin
                ready_d = i_acq_trig_ready & ~trig_busy[0];
            end else begin
                ready_d = i_frame_trig_ready & ~trig_busy[1];
            end
        end
    end

    // ============================================================
    // Setting readback
    reg [23:0] rdata_q;
    reg [23:0] rdata_d;

    always @* begin
        rdata_d = 24'h000000;
        case (i_cfg_param)
            `CIOC_PARAM_FILTER: begin
                if (i_io_line_select[1] == 1'b0) begin
                    rdata_d[`CIOC_FILTER_W-1:0] =
                        filt_all[i_io_line_select[0]*`CIOC_FILTER_W +:
                                 `CIOC_FILTER_W];
                end
            end
            `CIOC_PARAM_WIDTH: begin
                rdata_d[`CIOC_WIDTH_W-1:0] =
                    width_all[i_io_line_select*`CIOC_WIDTH_W +:
                              `CIOC_WIDTH_W];
            end
            `CIOC_PARAM_DELAY: begin
                rdata_d = delay_all[i_trigger_kind_select*`CIOC_DELAY_W +:
                                    `CIOC_DELAY_W];
            end
            default: begin
                rdata_d = 24'h000000;
            end
        endcase
    end

    always @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ready_q <= 1'b0;
            rdata_q <= 24'h000000;
        end else begin
            ready_q <= ready_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_ready_flag = ready_q;
    assign o_cfg_rdata  = rdata_q;

endmodule // cioc_top

// >>> testbench/cioc_checker.sv
`timescale 1ns/100ps

// ====================
// Port checker
module cioc_checker (
    // Clock and reset
    input logic       i_sys_clk,
    input logic       i_reset_n,
    // Lines
    input logic [1:0] i_line_in_pin,
    input logic [1:0] o_line_in,
    input logic [3:0] i_line_out_src,
    input logic [3:0] o_line_out_pin,
    // Triggers
    input logic       i_legacy_mode,
    input logic [1:0] i_trig_mode_on,
    input logic [1:0] i_sw_trig,
    input logic [1:0] i_hw_trig,
    input logic [1:0] i_int_trig,
    input logic [1:0] o_trig,
    input logic [1:0] o_trig_dropped,
    // Ready status
    input logic [1:0] i_ready_status_select,
    input logic       i_acq_trig_ready,
    input logic       o_ready_flag
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);

    // ====================
    // Lines
    // The filter time is hidden, so only the settled pin is tied to the level.
    a_filter_settled: assert property (
        $changed(o_line_in[0]) |-> $past(i_line_in_pin[0], 4) == o_line_in[0])
        else $error("filtered level differs from the settled pin");
    a_src_holds_pin: assert property (
        i_line_out_src[0] |=> o_line_out_pin[0])
        else $error("output pin low while its source is high");
    a_fall_after_src: assert property (
        $fell(o_line_out_pin[0]) |-> !$past(i_line_out_src[0]))
        else $error("output pin fell while its source was high");

    // ====================
    // Triggers
    a_int_when_off: assert property (
        !i_trig_mode_on[0] && i_int_trig[0] |=> o_trig[0])
        else $error("internal trigger lost with trigger mode off");
    a_sw_direct: assert property (
        i_trig_mode_on[0] && i_sw_trig[0] |=> o_trig[0])
        else $error("software trigger was delayed");
    a_legacy_frame: assert property (
        i_legacy_mode && i_trig_mode_on[1] && i_hw_trig[1] |=> o_trig[1])
        else $error("legacy frame trigger was delayed");

    // ====================
    // Ready status
    a_ready_select: assert property (
        i_ready_status_select != 2'h0 |=> !o_ready_flag)
        else $error("ready flag set under another status choice");
    a_ready_legacy: assert property (
        i_legacy_mode && !i_acq_trig_ready |=> !o_ready_flag)
        else $error("legacy ready flag set while start not accepted");
    a_legacy_up: assert property (
        i_legacy_mode && i_acq_trig_ready && !$past(i_trig_mode_on[0]) &&
        i_ready_status_select == 2'h0 |=> o_ready_flag)
        else $error("legacy ready flag low while start accepted");

    cover property (o_trig_dropped[0]);
    cover property ($rose(o_line_in[0]));
    cover property ($fell(o_line_out_pin[0]));
endmodule // cioc_checker

bind cioc_top cioc_checker i_chk (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_line_in_pin(i_line_in_pin), .o_line_in(o_line_in),
    .i_line_out_src(i_line_out_src), .o_line_out_pin(o_line_out_pin),
    .i_legacy_mode(i_legacy_mode), .i_trig_mode_on(i_trig_mode_on),
    .i_sw_trig(i_sw_trig), .i_hw_trig(i_hw_trig), .i_int_trig(i_int_trig),
    .o_trig(o_trig), .o_trig_dropped(o_trig_dropped),
    .i_ready_status_select(i_ready_status_select),
    .i_acq_trig_ready(i_acq_trig_ready), .o_ready_flag(o_ready_flag)
);

// >>> testbench/cioc_ext_model.sv
`timescale 1ns/100ps

// ====================
// Trigger source, pin driver and pulse receiver
module cioc_ext_model (
    // Clock
    input  wire       i_sys_clk,
    // Pins
    input  wire [3:0] i_out_pin,
    input  wire [1:0] i_meas_sel,
    output reg  [1:0] o_in_pin,
    output reg  [1:0] o_hw_trig,
    output reg  [7:0] o_width
);
    reg [7:0] run_q;

    initial begin
        o_in_pin = 2'h0;
        o_hw_trig = 2'h0;
        o_width = 8'h00;
        run_q = 8'h00;
    end

    // ====================
    // Receiver
    // Eight bits of cycles are enough for the widths exercised here.
    always @(posedge i_sys_clk) begin
        if (i_out_pin[i_meas_sel]) begin
            run_q <= run_q + 8'h01;
        end else begin
            if (run_q != 8'h00) begin
                o_width <= run_q;
            end
            run_q <= 8'h00;
        end
    end

    // Both tasks are entered at a falling edge.
    task automatic pin_pulse(input int ln, input int n);
        o_in_pin[ln] = 1'b1;
        repeat (n) @(negedge i_sys_clk);
        o_in_pin[ln] = 1'b0;
    endtask

    task automatic hw_pulse(input bit k);
        o_hw_trig[k] = 1'b1;
        @(negedge i_sys_clk);
        o_hw_trig[k] = 1'b0;
    endtask
endmodule // cioc_ext_model

// >>> testbench/tb_camera_io_signal_conditioning.sv
`timescale 1ns/100ps
`include "cioc_regs.vh"

module tb_camera_io_signal_conditioning;
    // ====================
    // Signals
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        we = 1'b0;
    logic        ksel = 1'b0;
    logic        legacy = 1'b0;
    logic        acq_rdy = 1'b0;
    logic        frm_rdy = 1'b0;
    logic [1:0]  prm = 2'h0;
    logic [1:0]  lsel = 2'h0;
    logic [1:0]  mode_on = 2'h0;
    logic [1:0]  sw = 2'h0;
    logic [1:0]  intr = 2'h0;
    logic [1:0]  rsel = 2'h0;
    logic [1:0]  meas = 2'h0;
    logic [3:0]  src = 4'h0;
    logic [23:0] cdata = 24'h000000;
    wire  [23:0] rdata;
    wire  [1:0]  pin_in, line_in, hw, trig, dropped;
    wire  [3:0]  pin_out;
    wire  [7:0]  width;
    wire         rflag;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          hit, t0, drops, ntrig, kd, n;
    bit          seen;

    typedef struct {bit lg; bit on; bit kd; int s; int dus; int lat;} cioc_row_t;
    cioc_row_t rows [9] = '{'{0,1,0,0,1,25}, '{0,1,1,0,2,50}, '{0,1,0,0,0,0},
        '{0,1,0,1,1,0}, '{0,0,0,0,1,-1}, '{0,0,0,2,1,0}, '{1,1,1,0,2,0},
        '{1,1,0,0,1,25}, '{0,1,1,2,0,-1}};

    always #20 clk = ~clk;

    cioc_top i_dut (
        .i_sys_clk(clk), .i_reset_n(rst_n), .i_cfg_we(we), .i_cfg_param(prm),
        .i_io_line_select(lsel), .i_trigger_kind_select(ksel),
        .i_cfg_data(cdata), .o_cfg_rdata(rdata), .i_line_in_pin(pin_in),
        .o_line_in(line_in), .i_line_out_src(src), .o_line_out_pin(pin_out),
        .i_legacy_mode(legacy), .i_trig_mode_on(mode_on), .i_hw_trig(hw),
        .i_sw_trig(sw), .i_int_trig(intr), .o_trig(trig),
        .o_trig_dropped(dropped), .i_ready_status_select(rsel),
        .i_acq_trig_ready(acq_rdy), .i_frame_trig_ready(frm_rdy),
        .o_ready_flag(rflag));

    cioc_ext_model i_ext (
        .i_sys_clk(clk), .i_out_pin(pin_out), .i_meas_sel(meas),
        .o_in_pin(pin_in), .o_hw_trig(hw), .o_width(width));

    // ====================
    // Monitor
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (trig[kd] === 1'b1) begin
            hit = cyc;
            ntrig++;
        end
        if (dropped[0] === 1'b1) drops++;
        if (line_in[0] === 1'b1) seen = 1'b1;
    end

    // ====================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic cfg(input logic [1:0] p, input logic [1:0] l, input logic k,
                       input logic [23:0] d);
        @(negedge clk);
        we = 1'b1;
        prm = p;
        lsel = l;
        ksel = k;
        cdata = d;
        @(negedge clk);
        we = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    task automatic fire(input int s, input bit k);
        @(negedge clk);
        t0 = cyc + 1;
        if (s == 0) begin
            i_ext.hw_pulse(k);
        end else begin
            if (s == 1) sw[k] = 1'b1;
            else intr[k] = 1'b1;
            @(negedge clk);
            sw = 2'h0;
            intr = 2'h0;
        end
    endtask

    task automatic lat_in(input int ln, input int len);
        fork
            i_ext.pin_pulse(ln, len);
            begin
                n = 0;
                do begin
                    @(negedge clk);
                    n++;
                end while (line_in[ln] !== 1'b1 && n < 99);
            end
        join
        repeat (40) @(negedge clk);
    endtask

    task automatic stretch(input int ln, input int len, input int e);
        meas = ln[1:0];
        src[ln] = 1'b1;
        repeat (len) @(negedge clk);
        src[ln] = 1'b0;
        repeat (70) @(negedge clk);
        chk("pulse width", e, width);
    endtask

    task automatic rdy(input logic e);
        repeat (3) @(negedge clk);
        chk("ready flag", e, rflag);
    endtask

    task automatic final_report();
        $display("checked %0d mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // A full run takes about 1400 cycles; the margin is generous.
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        final_report();
    end

    // ====================
    // Sequence
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            legacy = rows[i].lg;
            mode_on = {2{rows[i].on}};
            kd = rows[i].kd;
            cfg(`CIOC_PARAM_DELAY, 2'h0, rows[i].kd, rows[i].dus[23:0]);
            hit = -1;
            fire(rows[i].s, rows[i].kd);
            repeat (60) @(negedge clk);
            chk("trigger latency", rows[i].lat,
                (hit < 0) ? -1 : hit - t0);
        end
        $display("test trigger table done");
        legacy = 1'b0;
        mode_on = 2'h3;
        kd = 0;
        cfg(`CIOC_PARAM_DELAY, 2'h0, 1'b0, 24'h000001);
        drops = 0;
        ntrig = 0;
        fire(0, 1'b0);
        repeat (5) @(negedge clk);
        fire(0, 1'b0);
        repeat (60) @(negedge clk);
        chk("dropped count", 1, drops);
        chk("delayed count", 1, ntrig);
        rdy(1'b0);
        frm_rdy = 1'b1;
        cfg(`CIOC_PARAM_DELAY, 2'h0, 1'b1, 24'h000002);
        fire(0, 1'b1);
        rdy(1'b0);
        repeat (60) @(negedge clk);
        rdy(1'b1);
        legacy = 1'b1;
        mode_on = 2'h0;
        rdy(1'b0);
        acq_rdy = 1'b1;
        rdy(1'b1);
        rsel = 2'h1;
        rdy(1'b0);
        $display("test trigger extras done");
        cfg(`CIOC_PARAM_FILTER, 2'h0, 1'b0, 24'h000001);
        seen = 1'b0;
        lat_in(0, 24);
        chk("glitch passed", 0, seen);
        lat_in(0, 25);
        chk("filter latency", 28, n);
        lat_in(1, 5);
        chk("line 1 latency", 4, n);
        $display("test input filter done");
        cfg(`CIOC_PARAM_WIDTH, 2'h0, 1'b0, 24'h000001);
        cfg(`CIOC_PARAM_WIDTH, 2'h3, 1'b0, 24'h000002);
        stretch(0, 1, 25);
        stretch(0, 30, 30);
        stretch(3, 1, 50);
        stretch(1, 3, 3);
        $display("test stretcher done");
        cfg(`CIOC_PARAM_WIDTH, 2'h2, 1'b0, 24'hFFFFFF);
        chk("width clamp", `CIOC_WIDTH_MAX_US, rdata);
        cfg(`CIOC_PARAM_FILTER, 2'h0, 1'b0, 24'hFFFFFF);
        chk("filter clamp", `CIOC_FILTER_MAX_US, rdata);
        cfg(`CIOC_PARAM_FILTER, 2'h2, 1'b0, 24'h000005);
        chk("no third input", 0, rdata);
        cfg(`CIOC_PARAM_DELAY, 2'h0, 1'b0, 24'hFFFFFF);
        chk("delay clamp", `CIOC_DELAY_MAX_US, rdata);
        $display("test settings done");
        legacy = 1'b0;
        mode_on = 2'h3;
        fire(0, 1'b0);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        chk("outputs in reset", 0, {trig, pin_out, line_in});
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk("delay after reset", 0, rdata);
        hit = -1;
        fire(0, 1'b0);
        repeat (5) @(negedge clk);
        chk("latency after reset", 0, hit - t0);
        $display("test reset done");
        final_report();
    end
endmodule // tb_camera_io_signal_conditioning
